// >>> rtl/sys_seq_map.svh
// Contract
// - Bus ticks at quarter of selected source
// - POR/low voltage: clocks off, pin low 4096
// - Stop exit waits 4096 or 32 cycles
// - Wait mode stops CPU clocks only
// - Every reset asserts reset, picks vector
// - Internal reset returns registers to defaults
// - Internal reset clears counter, pin does not
// - Each reset source sets own cause flag
// - Pin low 67 cycles sets pin flag
// - After POR/low voltage, 4163 cycles needed
// - Internal reset: pin 32, then 32 more
// - POR/low voltage: 4096 count, then sequence
// - Watchdog request independent of bus phase
// - POR releases CPU 64 cycles after 4096
// - POR enables clock output, sets POR only
// - Watchdog overflow resets, flags, drives pin
// - Service write clears watchdog, counter 12:4
// - Counter overflow clocks the watchdog
// - Watchdog disabled only by test voltage logic
// - Internal counter is 13 bits wide
// - Short recovery option gives 32 cycles
`ifndef SYS_SEQ_MAP_SVH
`define SYS_SEQ_MAP_SVH

`define CNT_W 13
`define CNT_ONES 13'h1fff
`define CNT_ZERO 13'h0000
`define POR_LAST 13'h0fff
`define DRIVE_LAST 13'h001f
`define HOLD_LAST 13'h003f
`define STOP_LONG_LAST 13'h0fff
`define STOP_SHORT_LAST 13'h001f
`define SERVICE_KEEP 13'h000f
`define PIN_MIN_CYCLES 13'h0043
`define PIN_MIN_POR_CYCLES 4163
`define BUS_DIV_LAST 2'h3
`define WD_WIDTH 6
`define VEC_USER 16'hfffe
`define VEC_MONITOR 16'hfefe

`define REG_CAUSE 12'h000
`define REG_CONTROL 12'h004
`define REG_STATUS 12'h008
`define REG_WD_SERVICE 12'h00c

`define CAUSE_W 6
`define CAUSE_POR 0
`define CAUSE_PIN 1
`define CAUSE_WDOG 2
`define CAUSE_ILOP 3
`define CAUSE_ILAD 4
`define CAUSE_LOW_V 5
`define CAUSE_RESET 6'h01
`define CTRL_SSR 0
`define CTRL_RESET 1'h0

`endif

// >>> rtl/sys_seq_pkg.sv
package sys_seq_pkg;
	typedef enum logic [2:0] {
		ST_POR, ST_DRIVE, ST_HOLD, ST_EXT_PIN, ST_RUN, ST_WAIT, ST_STOP, ST_STOP_REC
	} seq_state_t;
	typedef logic [12:0] count_t;
endpackage

// >>> rtl/system_clock_reset_sequencer.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "sys_seq_map.svh"
module system_clock_reset_sequencer import sys_seq_pkg::*; #(
	parameter int P_PIN_MIN_POR_CYCLES = `PIN_MIN_POR_CYCLES,
	parameter int P_WD_WIDTH = `WD_WIDTH
) (
	input wire logic I_CLOCK,
	input wire logic I_RST,
	input wire logic I_PLL_SELECT,
	input wire logic I_PLL_CLK_EN,
	input wire logic I_LOW_VOLTAGE,
	input wire logic I_ILLEGAL_OPCODE,
	input wire logic I_OPCODE_FETCH,
	input wire logic I_UNMAPPED_FETCH,
	input wire logic I_STOP_REQ,
	input wire logic I_WAIT_REQ,
	input wire logic I_WAKE,
	input wire logic I_MONITOR_MODE,
	input wire logic I_BREAK,
	input wire logic I_RST_PIN_TEST_HV,
	input wire logic I_IRQ_PIN_TEST_HV,
	input wire logic I_RST_PIN_I,
	output logic O_RST_PIN_O,
	output logic O_RST_PIN_OE,
	output logic O_INTERNAL_RESET,
	output logic [15:0] O_RESET_VECTOR,
	output logic O_CLKGEN_OUT_EN,
	output logic O_CPU_CLK_EN,
	output logic O_PERIPH_CLK_EN,
	output logic O_CPU_BUS_TICK,
	output logic O_PERIPH_BUS_TICK,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR
);

	seq_state_t state_ff;
	count_t cnt_ff;
	count_t pin_cnt_ff;
	logic [1:0] div_ff;
	logic [P_WD_WIDTH-1:0] wd_cnt_ff;
	logic [`CAUSE_W-1:0] cause_ff;
	logic ctrl_ssr_ff;
	logic pin_meta_ff;
	logic pin_sync_ff;
	logic power_event_ff;
	logic clkgen_en_ff;
	logic cpu_tick_ff;
	logic periph_tick_ff;
	logic [15:0] vector_ff;
	logic [31:0] prdata_ff;

	logic cpu_en;
	logic periph_en;
	logic in_reset;
	logic src_tick;
	logic bus_tick;
	logic wd_disable;
	logic wd_tick;
	logic wd_fire;
	logic ilop_evt;
	logic ilad_evt;
	logic int_evt;
	logic ext_evt;
	logic go_drive;
	logic go_stop;
	logic service;
	logic pin_flag_set;
	logic setup;
	logic access;
	count_t stop_last;
	count_t pin_thr;

	function automatic logic reg_hit(input logic [11:0] addr);
		reg_hit = addr == `REG_CAUSE || addr == `REG_CONTROL ||
			addr == `REG_STATUS || addr == `REG_WD_SERVICE;
	endfunction

	// CPU clocks only run in user state; wait keeps peripherals alive
	always_comb begin
		cpu_en = state_ff == ST_RUN;
		periph_en = state_ff == ST_RUN || state_ff == ST_WAIT;
		in_reset = state_ff == ST_POR || state_ff == ST_DRIVE ||
			state_ff == ST_HOLD || state_ff == ST_EXT_PIN;
	end

	// Source ticks come from the reference clock or the PLL enable
	assign src_tick = I_PLL_SELECT ? I_PLL_CLK_EN : 1'b1;
	assign bus_tick = src_tick && div_ff == `BUS_DIV_LAST;

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			div_ff <= 2'h0;
		end else if (src_tick) begin
			div_ff <= div_ff + 2'h1;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			cpu_tick_ff <= 1'b0;
			periph_tick_ff <= 1'b0;
		end else begin
			cpu_tick_ff <= bus_tick && cpu_en;
			periph_tick_ff <= bus_tick && periph_en;
		end
	end

	// Reset pin arrives unsynchronised; only the second stage is used
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			// Idle level of the pulled-up pin, so release shows no false low
			pin_meta_ff <= 1'b1;
			pin_sync_ff <= 1'b1;
		end else begin
			pin_meta_ff <= I_RST_PIN_I;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// Purely combinational so noise cannot latch a disable
	assign wd_disable = (I_MONITOR_MODE && (I_RST_PIN_TEST_HV || I_IRQ_PIN_TEST_HV)) ||
		(I_BREAK && I_RST_PIN_TEST_HV);
	assign wd_tick = cnt_ff == `CNT_ONES && periph_en && !wd_disable;
	// Overflow acts on the reference clock, not on a bus phase
	assign wd_fire = wd_tick && wd_cnt_ff == {P_WD_WIDTH{1'b1}};
	assign ilop_evt = state_ff == ST_RUN && I_ILLEGAL_OPCODE;
	assign ilad_evt = state_ff == ST_RUN && I_OPCODE_FETCH && I_UNMAPPED_FETCH;
	assign int_evt = wd_fire || ilop_evt || ilad_evt;
	assign ext_evt = !pin_sync_ff && (periph_en || state_ff == ST_STOP ||
		state_ff == ST_STOP_REC);
	assign go_drive = int_evt || (state_ff == ST_POR && cnt_ff == `POR_LAST);
	assign go_stop = state_ff == ST_RUN && !int_evt && !ext_evt && I_STOP_REQ;
	assign stop_last = ctrl_ssr_ff ? `STOP_SHORT_LAST : `STOP_LONG_LAST;

	always_ff @(posedge I_CLOCK) begin
		if (I_RST || I_LOW_VOLTAGE) begin
			state_ff <= ST_POR;
		end else begin
			unique case (state_ff)
				ST_POR: begin
					if (go_drive) state_ff <= ST_DRIVE;
				end
				ST_DRIVE: begin
					if (cnt_ff == `DRIVE_LAST) state_ff <= ST_HOLD;
				end
				ST_HOLD: begin
					if (cnt_ff == `HOLD_LAST) state_ff <= ST_RUN;
				end
				ST_EXT_PIN: begin
					if (pin_sync_ff) state_ff <= ST_RUN;
				end
				ST_RUN: begin
					if (int_evt) state_ff <= ST_DRIVE;
					else if (ext_evt) state_ff <= ST_EXT_PIN;
					else if (I_STOP_REQ) state_ff <= ST_STOP;
					else if (I_WAIT_REQ) state_ff <= ST_WAIT;
				end
				ST_WAIT: begin
					if (int_evt) state_ff <= ST_DRIVE;
					else if (ext_evt) state_ff <= ST_EXT_PIN;
					else if (I_WAKE) state_ff <= ST_RUN;
				end
				ST_STOP: begin
					if (ext_evt) state_ff <= ST_EXT_PIN;
					else if (I_WAKE) state_ff <= ST_STOP_REC;
				end
				ST_STOP_REC: begin
					if (ext_evt) state_ff <= ST_EXT_PIN;
					else if (cnt_ff == stop_last) state_ff <= ST_RUN;
				end
			endcase
		end
	end

	// One 13-bit counter times power-on, reset sequence and stop recovery
	always_ff @(posedge I_CLOCK) begin
		if (I_RST || I_LOW_VOLTAGE) begin
			cnt_ff <= `CNT_ZERO;
		end else if (go_drive || go_stop) begin
			cnt_ff <= `CNT_ZERO;
		end else if (service) begin
			cnt_ff <= cnt_ff & `SERVICE_KEEP;
		end else if (state_ff != ST_STOP) begin
			cnt_ff <= cnt_ff + 13'h0001;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST || in_reset || service) begin
			wd_cnt_ff <= '0;
		end else if (wd_tick) begin
			wd_cnt_ff <= wd_cnt_ff + 1'b1;
		end
	end

	// Pin-low duration; the threshold is longer after a power event
	always_ff @(posedge I_CLOCK) begin
		if (I_RST || pin_sync_ff) begin
			pin_cnt_ff <= `CNT_ZERO;
		end else if (pin_cnt_ff != `CNT_ONES) begin
			pin_cnt_ff <= pin_cnt_ff + 13'h0001;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST || I_LOW_VOLTAGE) begin
			power_event_ff <= 1'b1;
		end else if (pin_sync_ff && !in_reset) begin
			power_event_ff <= 1'b0;
		end
	end

	assign pin_thr = power_event_ff ? 13'(P_PIN_MIN_POR_CYCLES - 1) :
		`PIN_MIN_CYCLES - 13'h0001;
	assign pin_flag_set = !pin_sync_ff && pin_cnt_ff == pin_thr;

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			cause_ff <= `CAUSE_RESET;
		end else begin
			if (I_LOW_VOLTAGE) cause_ff[`CAUSE_LOW_V] <= 1'b1;
			if (wd_fire) cause_ff[`CAUSE_WDOG] <= 1'b1;
			if (ilop_evt) cause_ff[`CAUSE_ILOP] <= 1'b1;
			if (ilad_evt) cause_ff[`CAUSE_ILAD] <= 1'b1;
			if (pin_flag_set) cause_ff[`CAUSE_PIN] <= 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			clkgen_en_ff <= 1'b0;
			vector_ff <= `VEC_USER;
		end else begin
			clkgen_en_ff <= 1'b1;
			vector_ff <= I_MONITOR_MODE ? `VEC_MONITOR : `VEC_USER;
		end
	end

	// Zero-wait APB: read data is captured in the setup cycle
	assign setup = I_PSEL && !I_PENABLE;
	assign access = I_PSEL && I_PENABLE;
	assign service = access && I_PWRITE && I_PADDR == `REG_WD_SERVICE;

	always_ff @(posedge I_CLOCK) begin
		if (I_RST || in_reset) begin
			ctrl_ssr_ff <= `CTRL_RESET;
		end else if (access && I_PWRITE && I_PADDR == `REG_CONTROL) begin
			ctrl_ssr_ff <= I_PWDATA[`CTRL_SSR];
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup && !I_PWRITE) begin
			unique case (I_PADDR)
				`REG_CAUSE: prdata_ff <= {26'h0, cause_ff};
				`REG_CONTROL: prdata_ff <= {31'h0, ctrl_ssr_ff};
				`REG_STATUS: prdata_ff <= {16'h0, 3'(state_ff), cnt_ff};
				`REG_WD_SERVICE: prdata_ff <= 32'(wd_cnt_ff);
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign O_PRDATA = prdata_ff;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = access && !reg_hit(I_PADDR);

	assign O_RST_PIN_O = 1'b0;
	assign O_RST_PIN_OE = state_ff == ST_POR || state_ff == ST_DRIVE;
	assign O_INTERNAL_RESET = in_reset;
	assign O_RESET_VECTOR = vector_ff;
	assign O_CLKGEN_OUT_EN = clkgen_en_ff;
	assign O_CPU_CLK_EN = cpu_en;
	assign O_PERIPH_CLK_EN = periph_en;
	assign O_CPU_BUS_TICK = cpu_tick_ff;
	assign O_PERIPH_BUS_TICK = periph_tick_ff;

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	sequence s_drive_phase;
		(state_ff == ST_DRIVE && O_RST_PIN_OE)[*8];
	endsequence

	sequence s_hold_then_run;
		(state_ff == ST_HOLD && !O_RST_PIN_OE && O_INTERNAL_RESET) ##32 (state_ff == ST_RUN);
	endsequence

	// Low voltage restarts the whole sequence, so it cancels the check
	property p_internal_seq;
		disable iff (I_RST || I_LOW_VOLTAGE)
		go_drive |=> s_drive_phase ##25 s_hold_then_run;
	endproperty
	a_internal_seq: assert property (p_internal_seq) else $error("reset pin/hold timing");

	property p_por_clocks_off;
		state_ff == ST_POR |-> O_RST_PIN_OE && !O_CPU_CLK_EN && !O_PERIPH_CLK_EN;
	endproperty
	a_por_clocks_off: assert property (p_por_clocks_off) else $error("clocks during POR");

	property p_por_end;
		state_ff == ST_POR && cnt_ff == `POR_LAST && !I_LOW_VOLTAGE |=>
			state_ff == ST_DRIVE && cnt_ff == `CNT_ZERO;
	endproperty
	a_por_end: assert property (p_por_end) else $error("POR count end wrong");

	property p_wait_clocks;
		state_ff == ST_WAIT |-> !O_CPU_CLK_EN && O_PERIPH_CLK_EN;
	endproperty
	a_wait_clocks: assert property (p_wait_clocks) else $error("wait clock gating");

	property p_vector;
		O_INTERNAL_RESET && $stable(I_MONITOR_MODE) |->
			O_RESET_VECTOR == (I_MONITOR_MODE ? `VEC_MONITOR : `VEC_USER);
	endproperty
	a_vector: assert property (p_vector) else $error("reset vector wrong");

	property p_wd_fire;
		wd_fire && !I_LOW_VOLTAGE |=> cause_ff[`CAUSE_WDOG] && state_ff == ST_DRIVE && O_RST_PIN_OE;
	endproperty
	a_wd_fire: assert property (p_wd_fire) else $error("watchdog reset missing");

	property p_service;
		service && !go_drive && !I_LOW_VOLTAGE |=> cnt_ff[12:4] == 9'h000 && wd_cnt_ff == '0;
	endproperty
	a_service: assert property (p_service) else $error("service clear failed");

	// Ticks and clears land one edge late, so the cycle before must be quiet too
	property p_wd_disable;
		wd_disable && $past(wd_disable) && !$past(in_reset) && !$past(service) &&
			!$past(I_RST) |-> !wd_fire && $stable(wd_cnt_ff);
	endproperty
	a_wd_disable: assert property (p_wd_disable) else $error("watchdog ran while disabled");

	property p_ext_counter;
		state_ff == ST_EXT_PIN && $past(state_ff) == ST_EXT_PIN && !I_LOW_VOLTAGE &&
			!$past(service) |-> cnt_ff == $past(cnt_ff) + 13'h0001;
	endproperty
	a_ext_counter: assert property (p_ext_counter) else $error("pin reset touched counter");

	property p_stop_short;
		state_ff == ST_STOP_REC && ctrl_ssr_ff && cnt_ff == `STOP_SHORT_LAST && pin_sync_ff &&
			!I_LOW_VOLTAGE |=> state_ff == ST_RUN;
	endproperty
	a_stop_short: assert property (p_stop_short) else $error("short stop exit late");

	property p_pin_flag;
		!pin_sync_ff && pin_cnt_ff == `PIN_MIN_CYCLES - 13'h0001 && !power_event_ff |=>
			cause_ff[`CAUSE_PIN];
	endproperty
	a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set at 67");

	property p_pin_flag_por;
		power_event_ff && !cause_ff[1] && !I_LOW_VOLTAGE |=> !cause_ff[1] || $past(pin_cnt_ff) ==
			13'(P_PIN_MIN_POR_CYCLES - 1);
	endproperty
	a_pin_flag_por: assert property (p_pin_flag_por) else $error("pin flag early");

	property p_bus_tick;
		O_CPU_BUS_TICK |=> !O_CPU_BUS_TICK ##1 !O_CPU_BUS_TICK ##1 !O_CPU_BUS_TICK;
	endproperty
	a_bus_tick: assert property (p_bus_tick) else $error("bus tick faster than quarter");

endmodule

// >>> verif/reset_pin_partner.sv
`timescale 1ns/1ps
module reset_pin_partner (
	input wire logic i_clock,
	input wire logic i_start,
	input wire logic [7:0] i_cycles,
	input wire logic i_dev_oe,
	input wire logic i_dev_o,
	output logic o_pin
);
	logic [7:0] left_ff = 8'h00;
	// Pull-up on the wire: high once every party lets go
	assign o_pin = ((i_dev_oe && !i_dev_o) || left_ff != 8'h00) ? 1'h0 : 1'h1;
	always_ff @(posedge i_clock) begin
		if (i_start) begin
			left_ff <= i_cycles;
		end else if (left_ff != 8'h00) begin
			left_ff <= left_ff - 8'h01;
		end
	end
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst = 1, pll_sel = 0, pll_en = 0, lv = 0, ilop = 0, fetch = 0, unmap = 0;
	logic stop = 0, wreq = 0, wake = 0, mon = 0, rhv = 0, psel = 0, pen = 0, pwr = 0, start = 0;
	logic ihv = 0, brk = 0;
	logic pin, oe, po, ir, cken, pcken, ctick, ptick, cgen, pready, perr, err;
	logic [7:0] hold = 8'h00;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] vec;
	int errors = 0, checks = 0, n;
	always #4 clk = ~clk;
	// Source ticks every other cycle so the PLL path divides differently
	always @(posedge clk) pll_en <= pll_sel & ~pll_en;
	system_clock_reset_sequencer #(.P_WD_WIDTH(1)) system_clock_reset_sequencer_i (
		.I_CLOCK(clk), .I_RST(rst), .I_PLL_SELECT(pll_sel), .I_PLL_CLK_EN(pll_en),
		.I_LOW_VOLTAGE(lv), .I_ILLEGAL_OPCODE(ilop), .I_OPCODE_FETCH(fetch),
		.I_UNMAPPED_FETCH(unmap), .I_STOP_REQ(stop), .I_WAIT_REQ(wreq), .I_WAKE(wake),
		.I_MONITOR_MODE(mon), .I_BREAK(brk), .I_RST_PIN_TEST_HV(rhv),
		.I_IRQ_PIN_TEST_HV(ihv), .I_RST_PIN_I(pin), .O_RST_PIN_O(po), .O_RST_PIN_OE(oe),
		.O_INTERNAL_RESET(ir), .O_RESET_VECTOR(vec), .O_CLKGEN_OUT_EN(cgen),
		.O_CPU_CLK_EN(cken), .O_PERIPH_CLK_EN(pcken), .O_CPU_BUS_TICK(ctick),
		.O_PERIPH_BUS_TICK(ptick), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(perr));
	reset_pin_partner reset_pin_partner_i (.i_clock(clk), .i_start(start), .i_cycles(hold),
		.i_dev_oe(oe), .i_dev_o(po), .o_pin(pin));
	task automatic tally_and_finish;
		if (errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		if (pready !== 1'h1) begin
			errors++;
			tally_and_finish;
		end
		rd = prdata;
		err = perr;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic wait_sig(input int s, input logic v, input int lim);
		logic x;
		n = 0;
		do begin
			cyc(1);
			n++;
			x = (s == 0) ? ir : (s == 1) ? oe : cken;
		end while (x !== v && n < lim);
		if (x !== v) begin
			errors++;
			tally_and_finish;
		end
	endtask
	task automatic hit(input int s);
		@(posedge clk);
		case (s)
			0: ilop <= 1;
			1: {fetch, unmap} <= 2'h3;
			2: lv <= 1;
			3: wreq <= 1;
			4: stop <= 1;
			default: wake <= 1;
		endcase
		@(posedge clk);
		{ilop, fetch, unmap, lv, wreq, stop, wake} <= 7'h0;
		#1;
	endtask
	task automatic ticks(input int exp);
		int t;
		t = 0;
		repeat (40) begin
			cyc(1);
			t += ctick + ptick;
		end
		chk(t, exp);
	endtask
	task automatic int_rst(input int s, input logic [31:0] cause);
		if (s == 9) begin
			wait_sig(1, 1, 20000);
		end else begin
			hit(s);
		end
		chk({oe, ir, cken, pcken}, 4'hc);
		wait_sig(1, 0, 100);
		chk(n, 32);
		wait_sig(0, 0, 100);
		chk(n, 32);
		chk(vec, 16'hfffe);
		apb(0, 12'h000, 0);
		chk(rd, cause);
		apb(0, 12'h008, 0);
		chk(rd[12:7], 0);
	endtask
	task automatic pin_low(input logic [7:0] k);
		@(posedge clk);
		start <= 1;
		hold <= k;
		@(posedge clk);
		start <= 0;
	endtask
	initial begin
		cyc(12);
		chk({oe, ir, cken, pcken, cgen}, 5'h18);
		@(posedge clk);
		rst <= 0;
		wait_sig(1, 0, 5000);
		chk(n, 4128);
		wait_sig(0, 0, 100);
		chk(n, 32);
		chk({cgen, cken, pcken}, 3'h7);
		apb(0, 12'h000, 0);
		chk(rd, 32'h1);
		chk(vec, 16'hfffe);
		@(posedge clk);
		mon <= 1;
		cyc(3);
		chk(vec, 16'hfefe);
		@(posedge clk);
		mon <= 0;
		ticks(20);
		@(posedge clk);
		pll_sel <= 1;
		cyc(8);
		ticks(10);
		@(posedge clk);
		pll_sel <= 0;
		cyc(8);
		hit(3);
		chk({cken, pcken}, 2'h1);
		ticks(10);
		hit(5);
		chk(cken, 1);
		apb(1, 12'h004, 1);
		apb(0, 12'h004, 0);
		chk(rd, 1);
		apb(0, 12'h010, 0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		hit(4);
		chk({cken, pcken}, 2'h0);
		hit(5);
		wait_sig(2, 1, 200);
		chk(n >= 32 && n <= 36, 1);
		apb(1, 12'h004, 0);
		hit(4);
		hit(5);
		wait_sig(2, 1, 5000);
		chk(n >= 4096 && n <= 4100, 1);
		// Too short a pulse halts the core but must not be recorded
		pin_low(8'd20);
		cyc(10);
		chk(ir, 1);
		cyc(30);
		apb(0, 12'h000, 0);
		chk(rd, 32'h1);
		pin_low(8'd70);
		cyc(40);
		chk(ir, 1);
		cyc(40);
		chk(ir, 0);
		apb(0, 12'h000, 0);
		chk(rd, 32'h3);
		int_rst(0, 32'h0b);
		int_rst(1, 32'h1b);
		apb(1, 12'h00c, 32'h5a);
		apb(0, 12'h008, 0);
		chk(rd[12:5], 0);
		apb(0, 12'h00c, 0);
		chk(rd, 0);
		int_rst(9, 32'h1f);
		// Each disable path gets a window longer than one counter overflow
		for (int c = 0; c < 3; c++) begin
			apb(1, 12'h00c, 32'h0);
			{mon, rhv, ihv, brk} <= (c == 0) ? 4'hc : (c == 1) ? 4'ha : 4'h5;
			repeat (8300) begin
				cyc(1);
				if (ir !== 1'h0) chk(ir, 0);
			end
			chk(ir, 0);
			apb(0, 12'h00c, 32'h0);
			chk(rd, 0);
			@(posedge clk);
			{mon, rhv, ihv, brk} <= 4'h0;
		end
		hit(2);
		chk({oe, cken}, 2'h2);
		wait_sig(0, 0, 5000);
		chk(n > 4150 && n < 4170, 1);
		apb(0, 12'h000, 0);
		chk(rd, 32'h3f);
		tally_and_finish;
	end
endmodule
